// >>> rtl/atrb_top.sv
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
// Functional notes
// - Timing trim 0x315 drives core B: single, calibration on, input A.
// - Timing trim 0x31A drives core A, single mode, input B.
// - Timing trim 0x31B, reset zero: core B, single mode, input B.
// - Offset trim 0x344 bits 11:0: core A, dual, calibration, input A.
// - Offset trim 0x346 bits 11:0: core A, dual, calibration, input B.
// - Offset trim 0x348 drives core A, single mode, input A.
// - Offset bits 15:12 are read/write storage, reset zero, not applied.
// - After reset every trim loads its factory fuse value.
// - Trims set sampling instants; software reads and overwrites them.
module atrb_top
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  fuse_cb_s_ina_tt,
  input  wire logic [7:0]  fuse_ca_s_inb_tt,
  input  wire logic [7:0]  fuse_cb_s_inb_tt,
  input  wire logic [15:0] fuse_ca_d_ina_ot,
  input  wire logic [15:0] fuse_ca_d_inb_ot,
  input  wire logic [15:0] fuse_ca_s_ina_ot,
  output logic      [7:0]  core_a_timing,
  output logic             core_a_timing_vld,
  output logic      [7:0]  core_b_timing,
  output logic             core_b_timing_vld,
  output logic      [11:0] core_a_offset,
  output logic             core_a_offset_vld
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    atrb_pkg::atrb_state_t st;
    logic [7:0]            cb_s_ina_tt;
    logic [7:0]            ca_s_inb_tt;
    logic [7:0]            cb_s_inb_tt;
    logic [15:0]           ca_d_ina_ot;
    logic [15:0]           ca_d_inb_ot;
    logic [15:0]           ca_s_ina_ot;
    logic [2:0]            ctrl;
    logic                  dp_wr;
    logic [11:0]           dp_idx;
    logic [31:0]           rdata;
  } atrb_regs_t;

  atrb_regs_t s_q;
  atrb_regs_t s_d;
  logic       addr_ph;
  logic [11:0] a_idx;

  assign addr_ph   = hsel && hready && htrans[1];
  assign a_idx     = atrb_pkg::atrb_index(haddr);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;

  ////////////////////////////////////////////////////////////////////////
  // The fuse load takes one cycle after release, so the strap-like fuse
  // levels are captured by a clocked process rather than by the reset.
  always_comb
  begin
    s_d       = s_q;
    s_d.dp_wr = 1'b0;
    unique case (s_q.st)
      atrb_pkg::ATRB_LOAD:
      begin
        s_d.cb_s_ina_tt = fuse_cb_s_ina_tt;
        s_d.ca_s_inb_tt = fuse_ca_s_inb_tt;
        s_d.cb_s_inb_tt = fuse_cb_s_inb_tt;
        s_d.ca_d_ina_ot = fuse_ca_d_ina_ot;
        s_d.ca_d_inb_ot = fuse_ca_d_inb_ot;
        s_d.ca_s_ina_ot = fuse_ca_s_ina_ot;
        s_d.st          = atrb_pkg::ATRB_RUN;
      end
      atrb_pkg::ATRB_RUN:
      begin
        if (s_q.dp_wr)
        begin
          unique case (s_q.dp_idx)
            atrb_pkg::IDX_CB_S_INA_TT:
              s_d.cb_s_ina_tt = hwdata[7:0];
            atrb_pkg::IDX_CA_S_INB_TT:
              s_d.ca_s_inb_tt = hwdata[7:0];
            atrb_pkg::IDX_CB_S_INB_TT:
              s_d.cb_s_inb_tt = hwdata[7:0];
            atrb_pkg::IDX_CA_D_INA_OT:
              s_d.ca_d_ina_ot = hwdata[15:0];
            atrb_pkg::IDX_CA_D_INB_OT:
              s_d.ca_d_inb_ot = hwdata[15:0];
            atrb_pkg::IDX_CA_S_INA_OT:
              s_d.ca_s_ina_ot = hwdata[15:0];
            atrb_pkg::IDX_ROUTE_CTRL:
              s_d.ctrl = hwdata[2:0];
            default:
              s_d.ctrl = s_q.ctrl;
          endcase
        end
      end
      default: s_d.st = atrb_pkg::ATRB_LOAD;
    endcase
    if (addr_ph)
    begin
      s_d.dp_wr  = hwrite;
      s_d.dp_idx = a_idx;
      if (!hwrite)
      begin
        unique case (a_idx)
          atrb_pkg::IDX_CB_S_INA_TT:
            s_d.rdata = {24'h000000, s_d.cb_s_ina_tt};
          atrb_pkg::IDX_CA_S_INB_TT:
            s_d.rdata = {24'h000000, s_d.ca_s_inb_tt};
          atrb_pkg::IDX_CB_S_INB_TT:
            s_d.rdata = {24'h000000, s_d.cb_s_inb_tt};
          atrb_pkg::IDX_CA_D_INA_OT:
            s_d.rdata = {16'h0000, s_d.ca_d_ina_ot};
          atrb_pkg::IDX_CA_D_INB_OT:
            s_d.rdata = {16'h0000, s_d.ca_d_inb_ot};
          atrb_pkg::IDX_CA_S_INA_OT:
            s_d.rdata = {16'h0000, s_d.ca_s_ina_ot};
          atrb_pkg::IDX_ROUTE_CTRL:
            s_d.rdata = {29'h00000000, s_d.ctrl};
          atrb_pkg::IDX_LOAD_STAT:
            s_d.rdata = {31'h00000000, s_q.st == atrb_pkg::ATRB_RUN};
          default:                   s_d.rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q             <= '0;
      s_q.st          <= atrb_pkg::ATRB_LOAD;
      s_q.cb_s_inb_tt <= atrb_pkg::TT_RESET;
      s_q.ca_d_ina_ot <= atrb_pkg::OT_RESET;
      s_q.ctrl        <= atrb_pkg::CTRL_RESET;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Only the low twelve bits of an offset trim reach a core.
  atrb_route u_route
  (
    .dual_mode         (s_q.ctrl[atrb_pkg::CTRL_DUAL_BIT]),
    .sel_inb           (s_q.ctrl[atrb_pkg::CTRL_INB_BIT]),
    .fg_cal_en         (s_q.ctrl[atrb_pkg::CTRL_FG_BIT]),
    .cb_s_ina_tt       (s_q.cb_s_ina_tt),
    .ca_s_inb_tt       (s_q.ca_s_inb_tt),
    .cb_s_inb_tt       (s_q.cb_s_inb_tt),
    .ca_d_ina_ot       (s_q.ca_d_ina_ot[11:0]),
    .ca_d_inb_ot       (s_q.ca_d_inb_ot[11:0]),
    .ca_s_ina_ot       (s_q.ca_s_ina_ot[11:0]),
    .core_a_timing     (core_a_timing),
    .core_a_timing_vld (core_a_timing_vld),
    .core_b_timing     (core_b_timing),
    .core_b_timing_vld (core_b_timing_vld),
    .core_a_offset     (core_a_offset),
    .core_a_offset_vld (core_a_offset_vld)
  );

  ////////////////////////////////////////////////////////////////////////
  property p_fuse_load;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && s_q.st == atrb_pkg::ATRB_LOAD) |=>
      s_q.cb_s_ina_tt == $past(fuse_cb_s_ina_tt) &&
      s_q.ca_s_ina_ot == $past(fuse_ca_s_ina_ot);
  endproperty
  a_fuse_load: assert property (p_fuse_load)
    else $error("Trim did not take its fuse value.");

  property p_write_tt;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && s_q.st == atrb_pkg::ATRB_RUN && s_q.dp_wr &&
     s_q.dp_idx == atrb_pkg::IDX_CA_S_INB_TT) |=>
      s_q.ca_s_inb_tt == $past(hwdata[7:0]);
  endproperty
  a_write_tt: assert property (p_write_tt)
    else $error("Timing trim write lost.");

  property p_write_ot;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && s_q.st == atrb_pkg::ATRB_RUN && s_q.dp_wr &&
     s_q.dp_idx == atrb_pkg::IDX_CA_D_INB_OT) |=>
      s_q.ca_d_inb_ot == $past(hwdata[15:0]);
  endproperty
  a_write_ot: assert property (p_write_ot)
    else $error("Offset trim write lost, reserved bits included.");

  property p_route_b_ina;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ctrl == 3'h4) |-> core_b_timing_vld &&
      core_b_timing == s_q.cb_s_ina_tt && !core_a_timing_vld;
  endproperty
  a_route_b_ina: assert property (p_route_b_ina)
    else $error("Core B input A timing trim not routed.");

  property p_route_inb;
    @(posedge hclk) disable iff (!hresetn)
    (!s_q.ctrl[0] && s_q.ctrl[1]) |-> core_a_timing == s_q.ca_s_inb_tt &&
      core_b_timing == s_q.cb_s_inb_tt;
  endproperty
  a_route_inb: assert property (p_route_inb)
    else $error("Input B timing trims not routed.");

  property p_route_dual;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ctrl == 3'h5) |-> core_a_offset == s_q.ca_d_ina_ot[11:0] &&
      !core_b_timing_vld;
  endproperty
  a_route_dual: assert property (p_route_dual)
    else $error("Dual input A offset trim not routed.");

  property p_route_dual_b;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ctrl == 3'h7) |-> core_a_offset == s_q.ca_d_inb_ot[11:0];
  endproperty
  a_route_dual_b: assert property (p_route_dual_b)
    else $error("Dual input B offset trim not routed.");

  property p_route_single_off;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ctrl[1:0] == 2'h0) |-> core_a_offset_vld &&
      core_a_offset == s_q.ca_s_ina_ot[11:0];
  endproperty
  a_route_single_off: assert property (p_route_single_off)
    else $error("Single input A offset trim not routed.");

  property p_dual_nofg;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ctrl == 3'h1) |-> !core_a_offset_vld && !core_a_timing_vld &&
      !core_b_timing_vld;
  endproperty
  a_dual_nofg: assert property (p_dual_nofg)
    else $error("A trim reached a core with no matching mode.");

  property p_single_nofg;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ctrl == 3'h0) |-> !core_a_timing_vld && !core_b_timing_vld;
  endproperty
  a_single_nofg: assert property (p_single_nofg)
    else $error("Timing trim routed without calibration on input A.");

  // Until the fuse load the trims show their reset value.
  property p_reset_zero;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.st == atrb_pkg::ATRB_LOAD) |->
      s_q.cb_s_inb_tt == atrb_pkg::TT_RESET &&
      s_q.ca_d_ina_ot == atrb_pkg::OT_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Trim left reset with a nonzero value.");

  // A frozen bank must not take a bus write or a fuse value.
  property p_freeze;
    @(posedge hclk) disable iff (!hresetn)
    !clk_en |=> s_q == $past(s_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State moved while the clock enable was low.");

  property p_read_ctrl;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && hsel && hready && htrans[1] && !hwrite && !s_q.dp_wr &&
     a_idx == atrb_pkg::IDX_ROUTE_CTRL) |=>
      hrdata == {29'h00000000, $past(s_q.ctrl)};
  endproperty
  a_read_ctrl: assert property (p_read_ctrl)
    else $error("Control register read back wrong.");

endmodule : atrb_top

// >>> pkg/atrb_pkg.sv
package atrb_pkg;

  // Printed offsets are not all multiples of four: they are indices.
  localparam logic [11:0] IDX_CB_S_INA_TT = 12'h315;
  localparam logic [11:0] IDX_CA_S_INB_TT = 12'h31A;
  localparam logic [11:0] IDX_CB_S_INB_TT = 12'h31B;
  localparam logic [11:0] IDX_CA_D_INA_OT = 12'h344;
  localparam logic [11:0] IDX_CA_D_INB_OT = 12'h346;
  localparam logic [11:0] IDX_CA_S_INA_OT = 12'h348;
  // Control register of our own: mode, input select, calibration enable.
  localparam logic [11:0] IDX_ROUTE_CTRL  = 12'h3F0;
  // Status register of our own: fuse load done.
  localparam logic [11:0] IDX_LOAD_STAT   = 12'h3F1;

  localparam int          TT_W        = 8;
  localparam int          OT_W        = 16;
  localparam int          OT_VAL_W    = 12;
  localparam logic [7:0]  TT_RESET    = 8'h00;
  localparam logic [15:0] OT_RESET    = 16'h0000;
  localparam logic [15:0] OT_RSV_MASK = 16'hF000;

  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_INB_BIT  = 1;
  localparam int CTRL_FG_BIT   = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  localparam int NUM_TT = 3;
  localparam int NUM_OT = 3;

  typedef enum logic [1:0] {ATRB_LOAD, ATRB_RUN} atrb_state_t;

  function automatic logic [11:0] atrb_index(input logic [31:0] addr);
    return addr[13:2];
  endfunction : atrb_index

endpackage : atrb_pkg

// >>> rtl/atrb_route.sv
`timescale 1ns/1ps
module atrb_route
(
  input  wire logic        dual_mode,
  input  wire logic        sel_inb,
  input  wire logic        fg_cal_en,
  input  wire logic [7:0]  cb_s_ina_tt,
  input  wire logic [7:0]  ca_s_inb_tt,
  input  wire logic [7:0]  cb_s_inb_tt,
  input  wire logic [11:0] ca_d_ina_ot,
  input  wire logic [11:0] ca_d_inb_ot,
  input  wire logic [11:0] ca_s_ina_ot,
  output logic      [7:0]  core_a_timing,
  output logic             core_a_timing_vld,
  output logic      [7:0]  core_b_timing,
  output logic             core_b_timing_vld,
  output logic      [11:0] core_a_offset,
  output logic             core_a_offset_vld
);

  ////////////////////////////////////////////////////////////////////////
  // Unmatched combinations present zero with the valid flag low.
  always_comb
  begin
    core_a_timing     = 8'h00;
    core_a_timing_vld = 1'b0;
    core_b_timing     = 8'h00;
    core_b_timing_vld = 1'b0;
    core_a_offset     = 12'h000;
    core_a_offset_vld = 1'b0;
    if (!dual_mode && sel_inb)
    begin
      core_a_timing     = ca_s_inb_tt;
      core_a_timing_vld = 1'b1;
      core_b_timing     = cb_s_inb_tt;
      core_b_timing_vld = 1'b1;
    end
    else if (!dual_mode && fg_cal_en)
    begin
      core_b_timing     = cb_s_ina_tt;
      core_b_timing_vld = 1'b1;
    end
    if (!dual_mode && !sel_inb)
    begin
      core_a_offset     = ca_s_ina_ot;
      core_a_offset_vld = 1'b1;
    end
    else if (dual_mode && fg_cal_en)
    begin
      core_a_offset     = sel_inb ? ca_d_inb_ot
                                  : ca_d_ina_ot;
      core_a_offset_vld = 1'b1;
    end
  end

endmodule : atrb_route

// >>> dv/adc_trim_register_bank_tb_top.sv
`timescale 1ns/1ps
module adc_trim_register_bank_tb_top;
  logic        hclk;
  logic        hresetn;
  logic        clk_en;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  a_tt;
  logic        a_tt_vld;
  logic [7:0]  b_tt;
  logic        b_tt_vld;
  logic [11:0] a_ot;
  logic        a_ot_vld;
  logic [11:0] idx_tab [6];
  logic [15:0] fuse_tab [6];
  logic [15:0] cur [6];
  int          err_count;
  int          comparisons;

  atrb_top dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .fuse_cb_s_ina_tt(fuse_tab[0][7:0]), .fuse_ca_s_inb_tt(fuse_tab[1][7:0]),
    .fuse_cb_s_inb_tt(fuse_tab[2][7:0]), .fuse_ca_d_ina_ot(fuse_tab[3]),
    .fuse_ca_d_inb_ot(fuse_tab[4]), .fuse_ca_s_ina_ot(fuse_tab[5]),
    .core_a_timing(a_tt), .core_a_timing_vld(a_tt_vld),
    .core_b_timing(b_tt), .core_b_timing_vld(b_tt_vld),
    .core_a_offset(a_ot), .core_a_offset_vld(a_ot_vld));

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // The slave never stalls today, but the master still waits on hready.
  task bus_op(input logic is_wr, input logic [11:0] idx,
              input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {18'h00000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= is_wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : bus_op

  task rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus_op(1'b0, idx, 32'h0, q);
    check(q, exp);
  endtask : rd_chk

  task wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus_op(1'b1, idx, d, q);
  endtask : wr

  ////////////////////////////////////////////////////////////////////////////
  task test_fuse_load;
    for (int i = 0; i < 6; i++)
      rd_chk(idx_tab[i], {16'h0, fuse_tab[i]});
    rd_chk(atrb_pkg::IDX_LOAD_STAT, 32'h1);
    rd_chk(atrb_pkg::IDX_ROUTE_CTRL, 32'h0);
    $display("test fuse_load done");
  endtask : test_fuse_load

  // Reserved offset bits are storage only; timing trims keep eight bits.
  task test_rw;
    logic [31:0] wdat;
    for (int i = 0; i < 6; i++)
    begin
      cur[i] = (i < 3) ? 16'h00C3 + 16'(i * 17) : 16'hF5A5 - 16'(i * 257);
      wdat = {16'hFFFF, cur[i]} | ((i < 3) ? 32'hFF00 : 32'h0);
      wr(idx_tab[i], wdat);
      rd_chk(idx_tab[i], {16'h0, cur[i]});
    end
    rd_chk(idx_tab[3], {16'h0, cur[3]});
    wr(12'h300, 32'h0000_00FF);
    rd_chk(12'h300, 32'h0);
    $display("test read_write done");
  endtask : test_rw

  // A write made while the clock enable is low is lost, not delayed.
  task test_freeze;
    clk_en <= 1'b0;
    wr(atrb_pkg::IDX_ROUTE_CTRL, 32'h0000_0002);
    clk_en <= 1'b1;
    rd_chk(atrb_pkg::IDX_ROUTE_CTRL, 32'h0000_0007);
    check({a_ot_vld, a_ot}, {1'b1, cur[4][11:0]});
    check({b_tt_vld, a_tt_vld}, 32'h0);
    $display("test freeze done");
  endtask : test_freeze

  task test_route;
    logic d;
    logic b;
    logic f;
    for (int m = 0; m < 8; m++)
    begin
      {f, b, d} = 3'(m);
      wr(atrb_pkg::IDX_ROUTE_CTRL, 32'(m));
      @(posedge hclk);
      check({a_tt_vld, a_tt},
            (!d && b) ? {1'b1, cur[1][7:0]} : 9'h0);
      check({b_tt_vld, b_tt}, (!d && b) ? {1'b1, cur[2][7:0]} :
            (!d && f) ? {1'b1, cur[0][7:0]} : 9'h0);
      check({a_ot_vld, a_ot}, (!d && !b) ? {1'b1, cur[5][11:0]} :
            (d && f) ? {1'b1, b ? cur[4][11:0] : cur[3][11:0]} :
            13'h0);
    end
    $display("test routing done");
  endtask : test_route

  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // The tests take about 150 cycles; 5000 cycles is a wide margin.
  initial
  begin
    #200000;
    err_count++;
    end_of_test();
  end

  initial
  begin
    idx_tab = '{atrb_pkg::IDX_CB_S_INA_TT, atrb_pkg::IDX_CA_S_INB_TT,
                atrb_pkg::IDX_CB_S_INB_TT, atrb_pkg::IDX_CA_D_INA_OT,
                atrb_pkg::IDX_CA_D_INB_OT, atrb_pkg::IDX_CA_S_INA_OT};
    fuse_tab = '{16'h005A, 16'h00A7, 16'h003C, 16'h0ABC, 16'h0DEF, 16'h0123};
    cur = fuse_tab;
    err_count = 0;
    comparisons = 0;
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    test_fuse_load();
    test_route();
    test_rw();
    test_route();
    test_freeze();
    end_of_test();
  end
endmodule : adc_trim_register_bank_tb_top
